// ==== logic/axis_encoder_step_compare.sv ====
`timescale 1ns/1ps
`include "axis_cfg.svh"
//Function
// [R1] Each valid edge of either encoder channel moves the position by one, so four counts per line.
// [R2] Encoder pins are sampled every clock so 20 MHz quadrature at half duty loses no count.
// [R3] Any line receiver fault indication sets the sticky encoder fault status.
// [R4] Pulse outputs give step and direction by default, or separate CW and CCW pulses.
// [R5] A phase accumulator makes step rates from 0.1 to 5 million pulses per second.
// [R6] A rising capture input edge latches the position, even for pulses under 100 ns.
// [R7] A compare match drives the compare output within a few clocks and repeats fast.
// [R8] Compare runs as strobe, static level, toggle or one-shot.
// [R9] A loop tick fires every 1 ms, 500 us or 250 us as chosen by performance mode.
// [R10] Each tick writes a servo output of Kp times error plus Ki times sum plus Kd times delta.
// [R11] The derivative term differences errors taken every N ticks, N set by software.
// [R12] Every millisecond the limits and following error bound are checked.
// [R13] Amplifier on can be routed to any digital output instead of the dedicated enable.
// [R14] Home, limits, fault, enable and direction are mapped to chosen channel numbers; the code maps only the limits, enable and direction.
// [R15] Steps where both encoder channels change at once are ignored.
// [R16] Direction settles before a step in a new direction, and steps have a fixed high time.
module axis_encoder_step_compare
   import axis_pkg::*;
#(
   parameter int TICK_1MS_CYC = `TICK_1MS_US * `CLK_MHZ,
   parameter int TICK_500_CYC = `TICK_500_US * `CLK_MHZ,
   parameter int TICK_250_CYC = `TICK_250_US * `CLK_MHZ,
   parameter int MS_CYC = `TICK_1MS_US * `CLK_MHZ
) (
   // Clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_SRST,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Pins in
   input wire logic I_ENC_A,
   input wire logic I_ENC_B,
   input wire logic [3:0] I_ENC_FAULT,
   input wire logic I_CAPT,
   input wire logic [15:0] I_DIN,
   // Pins out
   output logic O_PULSE_A,
   output logic O_PULSE_B,
   output logic O_CMP,
   output logic O_AMP_EN,
   output logic [15:0] O_DOUT,
   output logic [31:0] O_SERVO,
   output logic O_TICK,
   output logic O_IRQ
);
   logic [`SYNC_W-1:0] s1_r, s2_r;
   logic a_p_r, b_p_r, capt_p_r;
   word_t ctrl_r, rate_r, pos_r, capt_r, cmp_r, cint_r, tgt_r, kpki_r, kd_r, fbnd_r;
   word_t map_r, dout_r, servo_nxt, rd_nxt;
   logic [`STS_W-1:0] sts_r, mask_r, sts_set;
   logic ack, wr, rd, hit, pos_wr;
   logic a, b, q_a, q_b, q_ok, q_both, q_up, capt_edge;
   logic [15:0] din;
   // Sync all pins through two flip-flops
   always_ff @(posedge I_REF_CLK) begin
      s1_r <= {I_DIN, I_CAPT, I_ENC_FAULT, I_ENC_B, I_ENC_A};
      s2_r <= s1_r;
   end
   assign a = s2_r[0];
   assign b = s2_r[1];
   assign din = s2_r[22:7];
   // APB handshake, one wait state
   assign ack = PSEL & PENABLE & PREADY;
   assign wr = ack & PWRITE;
   assign rd = ack & ~PWRITE;
   always_comb begin
      hit = 1'b1;
      rd_nxt = '0;
      unique case (PADDR)
         `A_CTRL: rd_nxt = ctrl_r;
         `A_RATE: rd_nxt = rate_r;
         `A_POS: rd_nxt = pos_r;
         `A_CAPT: rd_nxt = capt_r;
         `A_CMP: rd_nxt = cmp_r;
         `A_CINT: rd_nxt = cint_r;
         `A_TGT: rd_nxt = tgt_r;
         `A_KPKI: rd_nxt = kpki_r;
         `A_KD: rd_nxt = kd_r;
         `A_FBND: rd_nxt = fbnd_r;
         `A_MAP: rd_nxt = map_r;
         `A_DOUT: rd_nxt = dout_r;
         `A_STS: rd_nxt = {26'h0, sts_r};
         `A_MASK: rd_nxt = {26'h0, mask_r};
         `A_SERVO: rd_nxt = O_SERVO;
         `A_LIVE: rd_nxt = {din, 11'h0, s2_r[6:2]};
         default: hit = 1'b0;
      endcase
   end
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         PREADY <= 1'b0;
         PRDATA <= '0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY <= PSEL & PENABLE & ~PREADY;
         PRDATA <= (PSEL & PENABLE & ~PREADY & ~PWRITE) ? rd_nxt : 32'h0;
         PSLVERR <= PSEL & PENABLE & ~PREADY & ~hit;
      end
   end
   // Plain software registers
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         ctrl_r <= '0; rate_r <= '0; cint_r <= '0; tgt_r <= '0; kpki_r <= '0;
         kd_r <= '0; fbnd_r <= '0; map_r <= '0; dout_r <= '0; mask_r <= '0;
      end else if (wr) begin
         if (PADDR == `A_CTRL) ctrl_r <= PWDATA;
         if (PADDR == `A_RATE) rate_r <= PWDATA;
         if (PADDR == `A_CINT) cint_r <= PWDATA;
         if (PADDR == `A_TGT) tgt_r <= PWDATA;
         if (PADDR == `A_KPKI) kpki_r <= PWDATA;
         if (PADDR == `A_KD) kd_r <= PWDATA;
         if (PADDR == `A_FBND) fbnd_r <= PWDATA;
         if (PADDR == `A_MAP) map_r <= PWDATA;
         if (PADDR == `A_DOUT) dout_r <= PWDATA;
         if (PADDR == `A_MASK) mask_r <= PWDATA[`STS_W-1:0];
      end
   end
   // Quadrature decode
   always_ff @(posedge I_REF_CLK) begin
      a_p_r <= a;
      b_p_r <= b;
      capt_p_r <= s2_r[6];
   end
   assign q_a = a ^ a_p_r;
   assign q_b = b ^ b_p_r;
   assign q_ok = q_a ^ q_b; // [R15]
   assign q_both = q_a & q_b;
   assign q_up = a ^ b_p_r;
   assign pos_wr = wr && PADDR == `A_POS;
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) pos_r <= '0;
      else if (pos_wr) pos_r <= PWDATA;
      else if (q_ok) pos_r <= q_up ? pos_r + 32'h1 : pos_r - 32'h1; // [R1] [R2]
   end
   // Capture latch
   assign capt_edge = s2_r[6] & ~capt_p_r;
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) capt_r <= '0;
      else if (capt_edge) capt_r <= pos_r; // [R6]
   end
   // Step generator
   logic [31:0] acc_r, step_inc;
   logic [32:0] acc_sum;
   logic dir_r, pend_r;
   logic [7:0] hi_r, set_r;
   assign step_inc = rate_r[31] ? 32'h0 - rate_r : rate_r;
   assign acc_sum = {1'b0, acc_r} + {1'b0, step_inc};
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         acc_r <= '0; dir_r <= 1'b0; pend_r <= 1'b0; hi_r <= '0; set_r <= '0;
      end else begin
         acc_r <= acc_sum[31:0]; // [R5]
         if (acc_sum[32]) pend_r <= 1'b1;
         if (hi_r != 8'h0) hi_r <= hi_r - 8'h1;
         if (set_r != 8'h0) set_r <= set_r - 8'h1;
         if (dir_r != rate_r[31] && hi_r == 8'h0) begin
            dir_r <= rate_r[31];
            set_r <= 8'(`DIR_SET_CYC); // [R16]
         end else if (pend_r && hi_r == 8'h0 && set_r == 8'h0) begin
            pend_r <= acc_sum[32];
            hi_r <= 8'(`STEP_HI_CYC); // [R16]
         end
      end
   end
   // Pulse pair format
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         O_PULSE_A <= 1'b0;
         O_PULSE_B <= 1'b0;
      end else if (ctrl_r[`C_CWCCW]) begin
         O_PULSE_A <= hi_r != 8'h0 && !dir_r; // [R4]
         O_PULSE_B <= hi_r != 8'h0 && dir_r;
      end else begin
         O_PULSE_A <= hi_r != 8'h0; // [R4]
         O_PULSE_B <= dir_r;
      end
   end
   // Position compare
   cmp_mode_e mode;
   logic match, match_d_r, cmp_hit, armed_r;
   logic [7:0] pw_r;
   assign mode = cmp_mode_e'(ctrl_r[`C_MODE_LO+1:`C_MODE_LO]);
   assign match = pos_r == cmp_r;
   assign cmp_hit = match & ~match_d_r & armed_r;
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         cmp_r <= '0; match_d_r <= 1'b0; armed_r <= 1'b0; pw_r <= '0; O_CMP <= 1'b0;
      end else begin
         match_d_r <= match;
         if (pw_r != 8'h0) pw_r <= pw_r - 8'h1;
         if (wr && PADDR == `A_CTRL) armed_r <= PWDATA[`C_ARM];
         if (wr && PADDR == `A_CMP) cmp_r <= PWDATA;
         if (!armed_r && pw_r == 8'h0) O_CMP <= 1'b0; // Running pulse ends on its own
         else if (cmp_hit) begin
            unique case (mode) // [R8]
               CMP_STROBE: begin
                  O_CMP <= 1'b1; // [R7]
                  pw_r <= 8'(`CMP_PW_CYC);
                  cmp_r <= cmp_r + cint_r;
               end
               CMP_STATIC: O_CMP <= 1'b1;
               CMP_TOGGLE: O_CMP <= ~O_CMP;
               CMP_ONESHOT: begin
                  O_CMP <= 1'b1;
                  pw_r <= 8'(`CMP_PW_CYC);
                  armed_r <= 1'b0;
               end
            endcase
         end else if (pw_r == 8'h1 && (mode == CMP_STROBE || mode == CMP_ONESHOT))
            O_CMP <= 1'b0;
      end
   end
   // Loop tick and millisecond check timers
   logic [31:0] tick_cnt_r, tick_lim, ms_cnt_r;
   logic tick, ms;
   always_comb begin
      unique case (ctrl_r[`C_PERF_LO+1:`C_PERF_LO])
         2'h1: tick_lim = 32'(TICK_500_CYC - 1);
         2'h2, 2'h3: tick_lim = 32'(TICK_250_CYC - 1);
         default: tick_lim = 32'(TICK_1MS_CYC - 1);
      endcase
   end
   assign tick = tick_cnt_r >= tick_lim;
   assign ms = ms_cnt_r == 32'(MS_CYC - 1);
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         tick_cnt_r <= '0; ms_cnt_r <= '0; O_TICK <= 1'b0;
      end else begin
         tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1; // [R9]
         ms_cnt_r <= ms ? 32'h0 : ms_cnt_r + 32'h1;
         O_TICK <= tick;
      end
   end
   // Servo filter
   word_t err_r, integ_r, ed_r, edp_r;
   logic [15:0] ds_r;
   logic go_r;
   always_comb begin
      servo_nxt = 32'($signed(kpki_r[15:0]) * $signed(err_r))
         + 32'($signed(kpki_r[31:16]) * $signed(integ_r))
         + 32'($signed(kd_r[15:0]) * $signed(ed_r - edp_r));
   end
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         err_r <= '0; integ_r <= '0; ed_r <= '0; edp_r <= '0; ds_r <= '0;
         go_r <= 1'b0; O_SERVO <= '0;
      end else begin
         go_r <= tick;
         if (tick) begin
            err_r <= tgt_r - pos_r;
            integ_r <= integ_r + (tgt_r - pos_r);
            if (ds_r >= kd_r[31:16]) begin
               ds_r <= '0;
               edp_r <= ed_r; // [R11]
               ed_r <= tgt_r - pos_r;
            end else ds_r <= ds_r + 16'h1;
         end
         if (go_r) O_SERVO <= servo_nxt; // [R10]
      end
   end
   // Channel mapping and output routing
   logic lim_p, lim_m, ferr;
   assign lim_p = din[map_r[7:4]]; // [R14]
   assign lim_m = din[map_r[11:8]];
   assign ferr = (err_r[31] ? 32'h0 - err_r : err_r) > fbnd_r;
   for (genvar i = 0; i < 16; i++) begin : g_dout
      always_ff @(posedge I_REF_CLK) begin
         if (I_SRST) O_DOUT[i] <= 1'b0;
         else if (ctrl_r[`C_RT_AMP] && map_r[19:16] == 4'(i))
            O_DOUT[i] <= ctrl_r[`C_AMPON]; // [R13] [R14]
         else if (ctrl_r[`C_RT_DIR] && map_r[23:20] == 4'(i))
            O_DOUT[i] <= dir_r; // [R14]
         else O_DOUT[i] <= dout_r[i];
      end
   end
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) O_AMP_EN <= 1'b0;
      else O_AMP_EN <= ctrl_r[`C_AMPON] & ~ctrl_r[`C_RT_AMP]; // [R13]
   end
   // Sticky status, read clears, set wins
   always_comb begin
      sts_set = '0;
      sts_set[`S_ENC] = |s2_r[5:2]; // [R3]
      sts_set[`S_CAPT] = capt_edge;
      sts_set[`S_CMP] = cmp_hit;
      sts_set[`S_TICK] = tick;
      sts_set[`S_LIM] = ms & (lim_p | lim_m); // [R12]
      sts_set[`S_FERR] = ms & ferr; // [R12]
   end
   always_ff @(posedge I_REF_CLK) begin
      if (I_SRST) begin
         sts_r <= '0;
         O_IRQ <= 1'b0;
      end else begin
         sts_r <= ((rd && PADDR == `A_STS) ? '0 : sts_r) | sts_set;
         O_IRQ <= |(((rd && PADDR == `A_STS) ? '0 : sts_r) & mask_r | sts_set & mask_r);
      end
   end
   // Checks
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (I_SRST);
   property p_cnt;
      q_ok && !pos_wr |=> pos_r == $past(pos_r) + ($past(q_up) ? 32'h1 : 32'hFFFFFFFF);
   endproperty
   a_cnt: assert property (p_cnt) else $error("count step wrong"); // [R1]
   property p_both;
      q_both && !pos_wr |=> pos_r == $past(pos_r);
   endproperty
   a_both: assert property (p_both) else $error("double change counted"); // [R15]
   property p_fault;
      |s2_r[5:2] |=> sts_r[`S_ENC];
   endproperty
   a_fault: assert property (p_fault) else $error("fault not flagged"); // [R3]
   property p_hi;
      !ctrl_r[`C_CWCCW] && $rose(O_PULSE_A) |-> O_PULSE_A [*4];
   endproperty
   a_hi: assert property (p_hi) else $error("step too short"); // [R16]
   property p_capt;
      capt_edge |=> capt_r == $past(pos_r);
   endproperty
   a_capt: assert property (p_capt) else $error("capture missed"); // [R6]
   property p_tog;
      cmp_hit && mode == CMP_TOGGLE |=> O_CMP != $past(O_CMP);
   endproperty
   a_tog: assert property (p_tog) else $error("toggle failed"); // [R8]
   property p_strobe;
      cmp_hit && mode == CMP_STROBE |=> O_CMP ##1 (O_CMP [*2]);
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe late"); // [R7]
   property p_ferr;
      ms && ferr |=> sts_r[`S_FERR];
   endproperty
   a_ferr: assert property (p_ferr) else $error("follow error missed"); // [R12]
   property p_route;
      ctrl_r[`C_RT_AMP] && $stable(ctrl_r) |=> !O_AMP_EN;
   endproperty
   a_route: assert property (p_route) else $error("enable not rerouted"); // [R13]
   property p_svo;
      tick |=> ##1 O_SERVO == $past(servo_nxt);
   endproperty
   a_svo: assert property (p_svo) else $error("servo not written"); // [R10]
endmodule

// ==== logic/axis_cfg.svh ====
`ifndef AXIS_CFG_SVH
`define AXIS_CFG_SVH
// Register byte offsets
`define A_CTRL 8'h00
`define A_RATE 8'h04
`define A_POS 8'h08
`define A_CAPT 8'h0C
`define A_CMP 8'h10
`define A_CINT 8'h14
`define A_TGT 8'h18
`define A_KPKI 8'h1C
`define A_KD 8'h20
`define A_FBND 8'h24
`define A_MAP 8'h28
`define A_DOUT 8'h2C
`define A_STS 8'h30
`define A_MASK 8'h34
`define A_SERVO 8'h38
`define A_LIVE 8'h3C
// Control fields
`define C_CWCCW 0
`define C_AMPON 1
`define C_MODE_LO 2
`define C_ARM 4
`define C_PERF_LO 5
`define C_RT_AMP 7
`define C_RT_DIR 8
// Status bits
`define S_ENC 0
`define S_CAPT 1
`define S_CMP 2
`define S_TICK 3
`define S_LIM 4
`define S_FERR 5
`define STS_W 6
// Timing
`define CLK_MHZ 125
`define STEP_HI_NS 32
`define DIR_SET_NS 32
`define CMP_PW_NS 32
`define STEP_HI_CYC ((`STEP_HI_NS * `CLK_MHZ + 999) / 1000)
`define DIR_SET_CYC ((`DIR_SET_NS * `CLK_MHZ + 999) / 1000)
`define CMP_PW_CYC ((`CMP_PW_NS * `CLK_MHZ + 999) / 1000)
`define TICK_1MS_US 1000
`define TICK_500_US 500
`define TICK_250_US 250
`define SYNC_W 23
`endif

// ==== logic/axis_pkg.sv ====
package axis_pkg;
   typedef enum logic [1:0] {
      CMP_STROBE = 2'b00,
      CMP_STATIC = 2'b01,
      CMP_TOGGLE = 2'b10,
      CMP_ONESHOT = 2'b11
   } cmp_mode_e;
   typedef logic [31:0] word_t;
endpackage

// ==== verif/quad_model.sv ====
`timescale 1ns/1ps
// Quadrature encoder and capture trigger at the far side
module quad_model (
   // Clock
   input wire logic i_clk,
   // Pins
   output logic o_enc_a,
   output logic o_enc_b,
   output logic o_capt
);
   // Lines idle low
   initial begin
      o_enc_a = 1'h0;
      o_enc_b = 1'h0;
      o_capt = 1'h0;
   end
   // One channel per step, A leads B for up
   task automatic move(input int n, input logic up, input int gap);
      repeat (n) begin
         repeat (gap) @(posedge i_clk);
         if (o_enc_a ^ o_enc_b ^ up) o_enc_a <= ~o_enc_a;
         else o_enc_b <= ~o_enc_b;
      end
   endtask
   // Both channels at once, an illegal step
   task automatic jump();
      @(posedge i_clk);
      o_enc_a <= ~o_enc_a;
      o_enc_b <= ~o_enc_b;
   endtask
   // One clock wide trigger, well under 100 ns
   task automatic shot();
      @(posedge i_clk);
      o_capt <= 1'h1;
      @(posedge i_clk);
      o_capt <= 1'h0;
   endtask
endmodule

// ==== verif/axis_encoder_step_compare_tb.sv ====
`timescale 1ns/1ps
`include "axis_cfg.svh"
module axis_encoder_step_compare_tb;
   import axis_pkg::*;
   logic clk, srst, psel, penable, pwrite, capt, ea, eb, er;
   logic pready, pslverr, pa, pb, cmp, amp, tick, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, rd, prdata, servo;
   logic [3:0] fault;
   logic [15:0] din, dout;
   int num_errors = 0;
   int check_count = 0;
   int n, ca, cb;
   // Design with short tick and housekeeping periods
   axis_encoder_step_compare #(.TICK_1MS_CYC(40), .TICK_500_CYC(20), .TICK_250_CYC(10),
      .MS_CYC(40)) axis_encoder_step_compare_inst (.I_REF_CLK(clk), .I_SRST(srst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .I_ENC_A(ea), .I_ENC_B(eb),
      .I_ENC_FAULT(fault), .I_CAPT(capt), .I_DIN(din), .O_PULSE_A(pa), .O_PULSE_B(pb),
      .O_CMP(cmp), .O_AMP_EN(amp), .O_DOUT(dout), .O_SERVO(servo), .O_TICK(tick),
      .O_IRQ(irq));
   // Encoder and trigger source
   quad_model quad_model_inst (.i_clk(clk), .o_enc_a(ea), .o_enc_b(eb), .o_capt(capt));
   // 125 MHz clock
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected t=%0t got %h want %h", $time, g, e);
      end
   endtask
   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Wait bound exhausted
   task automatic tmo(input int k);
      if (k >= 200) begin
         $display("unexpected t=%0t wait ran out", $time);
         num_errors++;
         tally_and_finish();
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'h1 && k < 200);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      tmo(k);
      @(posedge clk);
   endtask
   // Read and compare under a mask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'h0, a, 32'h0);
      chk(rd & m, e);
   endtask
   task automatic wt(input int k);
      repeat (k) @(posedge clk);
   endtask
   // Cycles up to the next tick pulse
   task automatic gap(output int k);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (tick !== 1'h1 && k < 200);
      tmo(k);
   endtask
   // Rising edges on both pulse pins over 160 cycles
   task automatic steps();
      logic la, lb;
      ca = 0;
      cb = 0;
      la = pa;
      lb = pb;
      repeat (160) begin
         @(posedge clk);
         ca += int'(pa && !la);
         cb += int'(pb && !lb);
         la = pa;
         lb = pb;
      end
   endtask
   // Main sequence
   initial begin
      srst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      fault = 4'h0;
      din = 16'h0;
      repeat (20) @(posedge clk);
      srst <= 1'h0;
      @(posedge clk);
      rdc(`A_CTRL, '1, 32'h0);
      rdc(`A_POS, '1, 32'h0);
      apb(1'h0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
      $display("test reset done");
      quad_model_inst.move(8, 1'h1, 4);
      wt(6);
      rdc(`A_POS, '1, 32'h8);
      quad_model_inst.move(12, 1'h0, 2);
      wt(6);
      rdc(`A_POS, '1, 32'hFFFFFFFC);
      quad_model_inst.jump();
      wt(6);
      rdc(`A_POS, '1, 32'hFFFFFFFC);
      $display("test encoder done");
      apb(1'h1, `A_MASK, 32'h1);
      for (int i = 0; i < 4; i++) begin
         fault <= 4'h1 << i;
         wt(2);
         fault <= 4'h0;
         wt(4);
         chk({31'h0, irq}, 32'h1);
         rdc(`A_STS, 32'h1, 32'h1);
         wt(2);
         chk({31'h0, irq}, 32'h0);
      end
      $display("test fault done");
      apb(1'h1, `A_POS, 32'h1234);
      quad_model_inst.shot();
      wt(8);
      rdc(`A_CAPT, '1, 32'h1234);
      $display("test capture done");
      apb(1'h1, `A_CINT, 32'h1);
      for (int m = 0; m < 4; m++) begin
         apb(1'h1, `A_CTRL, 32'h0);
         apb(1'h1, `A_POS, 32'h1234);
         apb(1'h1, `A_CMP, 32'h1236);
         apb(1'h1, `A_CTRL, 32'h10 | (m << 2));
         quad_model_inst.move(2, 1'h1, 4);
         wt(6);
         chk({31'h0, cmp}, 32'h1);
         wt(14);
         chk({31'h0, cmp}, (m == 1 || m == 2) ? 32'h1 : 32'h0);
         // Strobe moved its compare point on by the interval
         if (m == 0) begin
            quad_model_inst.move(1, 1'h1, 4);
            wt(6);
            chk({31'h0, cmp}, 32'h1);
         end
      end
      $display("test compare done");
      apb(1'h1, `A_CTRL, 32'h0);
      apb(1'h1, `A_RATE, 32'h10000000);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pa !== 1'h1 && n < 200);
      tmo(n);
      n = 0;
      while (pa === 1'h1 && n < 200) begin
         @(posedge clk);
         n++;
      end
      chk(n, `STEP_HI_CYC);
      steps();
      chk(ca, 32'hA);
      apb(1'h1, `A_CTRL, 32'h1);
      steps();
      chk(ca + cb, 32'hA);
      chk(ca * cb, 32'h0);
      // Negative rate moves the pulses to the other pin
      apb(1'h1, `A_RATE, 32'hF0000000);
      wt(16);
      steps();
      chk(cb, 32'hA);
      chk(ca, 32'h0);
      apb(1'h1, `A_RATE, 32'h0);
      $display("test step done");
      for (int p = 0; p < 3; p++) begin
         apb(1'h1, `A_CTRL, 32'(p << 5));
         gap(n);
         gap(n);
         chk(n, 32'h28 >> p);
      end
      $display("test tick done");
      apb(1'h1, `A_CTRL, 32'h0);
      apb(1'h1, `A_POS, 32'h0);
      apb(1'h1, `A_TGT, 32'hA);
      apb(1'h1, `A_KPKI, 32'h2);
      gap(n);
      gap(n);
      wt(4);
      rdc(`A_SERVO, '1, 32'h14);
      apb(1'h1, `A_KD, 32'h3);
      apb(1'h1, `A_TGT, 32'hE);
      gap(n);
      wt(4);
      chk(servo, 32'h28);
      gap(n);
      wt(4);
      chk(servo, 32'h1C);
      $display("test servo done");
      apb(1'h1, `A_CTRL, 32'h2);
      apb(1'h1, `A_DOUT, 32'h2);
      wt(2);
      chk({31'h0, amp}, 32'h1);
      chk({31'h0, dout[1]}, 32'h1);
      apb(1'h1, `A_MAP, 32'h150030);
      apb(1'h1, `A_CTRL, 32'h182);
      wt(4);
      chk({31'h0, dout[5]}, 32'h1);
      chk({31'h0, amp}, 32'h0);
      chk({31'h0, dout[1]}, 32'h0);
      rdc(`A_STS, 32'h10, 32'h0);
      din <= 16'h0008;
      wt(60);
      rdc(`A_STS, 32'h30, 32'h30);
      rdc(`A_LIVE, 32'hFFFF001F, 32'h00080000);
      $display("test mapping done");
      tally_and_finish();
   end
endmodule
